// [rtl/dss_pkg.sv]
`default_nettype none
package dss_pkg;

    // ==========================================================
    // Clock and timing
    localparam int CLK_MHZ          = 200;
    localparam int ST_TIME_US       = 12000;
    localparam int ST_CYCLES        = ST_TIME_US * CLK_MHZ;
    localparam int STARTUP_TIME_US  = 1000;
    localparam int STARTUP_CYCLES   = STARTUP_TIME_US * CLK_MHZ;
    localparam int ST_MIN_CYCLES    = 16;

    // ==========================================================
    // Byte addresses of the register map
    localparam logic [6:0] ADDR_FLASH_WRITE_COUNTER = 7'h00;
    localparam logic [6:0] ADDR_MISC      = 7'h34;
    localparam logic [6:0] ADDR_MISC_HI   = 7'h35;
    localparam logic [6:0] ADDR_DELTA     = 7'h38;
    localparam logic [6:0] ADDR_DIAG      = 7'h3C;
    localparam logic [6:0] ADDR_GLOB      = 7'h3E;
    localparam logic [6:0] ADDR_GLOB_HI   = 7'h3F;
    localparam logic [6:0] ADDR_LOT_LO    = 7'h52;
    localparam logic [6:0] ADDR_LOT_HI    = 7'h54;
    localparam logic [6:0] ADDR_SERIAL    = 7'h58;
    localparam logic [6:0] ADDR_WORD_MASK = 7'h7E;

    // ==========================================================
    // Field positions
    localparam int GLOB_ST_BIT   = 2;
    localparam int GLOB_CLR_BIT  = 4;
    localparam int GLOB_FT_BIT   = 5;
    localparam int GLOB_CAPT_BIT = 11;
    localparam int MISC_ST_BIT   = 8;
    localparam int DG_SUP_LO     = 0;
    localparam int DG_SUP_HI     = 1;
    localparam int DG_FLASH_UPD  = 2;
    localparam int DG_SPI        = 3;
    localparam int DG_CAPT_VIOL  = 4;
    localparam int DG_ST         = 5;
    localparam int DG_FLASH_TEST = 6;
    localparam int DG_READY      = 7;
    localparam int DG_PEAK_LO    = 8;
    localparam int DG_SYS        = 11;
    localparam int DG_SRC_LO     = 12;
    localparam int DG_RSV        = 15;

    // ==========================================================
    // Reset values and limits
    localparam logic [15:0] MISC_RESET = 16'h0003;
    localparam logic [15:0] DIAG_RESET = 16'h0000;
    localparam logic [15:0] DELTA_MIN  = 16'h0010;
    localparam logic [15:0] DELTA_MAX  = 16'h7FFF;

    // ==========================================================
    // Carriers
    typedef struct packed {
        logic       wr;
        logic [6:0] addr;
        logic [7:0] data;
    } dss_frame_s;

    typedef struct packed {
        logic [2:0] event_src;
        logic [2:0] peak;
        logic       sys_alarm;
        logic       capture_done;
        logic       flash_upd_fail;
    } dss_events_s;

endpackage
`default_nettype wire

// [rtl/dss_spi_slave.sv]
`timescale 1ns/1ps
`default_nettype none
module dss_spi_slave (
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              srst,
    // Serial pins
    input  wire logic              sclk,
    input  wire logic              cs_n,
    input  wire logic              mosi,
    output logic                   miso,
    output logic                   miso_oe,
    // Word side
    input  wire logic [15:0]       tx_word,
    output dss_pkg::dss_frame_s    frame,
    output logic                   frame_valid,
    output logic                   frame_error
);
    import dss_pkg::*;

    logic [2:0]  sclk_q;
    logic [2:0]  cs_q;
    logic [1:0]  mosi_q;
    logic [14:0] rx;
    logic [3:0]  cnt;
    logic [15:0] tx_sh;
    logic        rise;
    logic        fall;
    logic        cs_act;
    logic        cs_end;

    // ==========================================================
    // Pin synchronisers
    always_ff @(posedge clk) begin
        if (srst) begin
            sclk_q <= 3'h7;
            cs_q   <= 3'h7;
            mosi_q <= 2'h0;
        end else begin
            sclk_q <= {sclk_q[1:0], sclk};
            cs_q   <= {cs_q[1:0], cs_n};
            mosi_q <= {mosi_q[0], mosi};
        end
    end

    assign rise   = sclk_q[1] & ~sclk_q[2];
    assign fall   = ~sclk_q[1] & sclk_q[2];
    assign cs_act = ~cs_q[1];
    assign cs_end = cs_q[1] & ~cs_q[2];

    // ==========================================================
    // Receive path, sampled on rising serial clock
    always_ff @(posedge clk) begin
        if (srst) begin
            rx  <= 15'h0000;
            cnt <= 4'h0;
        end else if (!cs_act) begin
            cnt <= 4'h0;
        end else if (rise) begin
            rx  <= {rx[13:0], mosi_q[1]};
            cnt <= cnt + 4'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            frame_valid <= 1'b0;
            frame       <= '0;
            frame_error <= 1'b0;
        end else begin
            frame_valid <= cs_act & rise & (cnt == 4'hF);
            if (cs_act && rise && cnt == 4'hF) begin
                frame <= {rx, mosi_q[1]};
            end
            // A count that is not a whole number of words leaves a remainder.
            frame_error <= cs_end & (cnt != 4'h0);
        end
    end

    // ==========================================================
    // Transmit path, changed on falling serial clock
    always_ff @(posedge clk) begin
        if (srst) begin
            miso    <= 1'b0;
            miso_oe <= 1'b0;
            tx_sh   <= 16'h0000;
        end else begin
            miso_oe <= cs_act;
            if (!cs_act) begin
                miso <= 1'b0;
            end else if (fall) begin
                if (cnt == 4'h0) begin
                    miso  <= tx_word[15];
                    tx_sh <= {tx_word[14:0], 1'b0};
                end else begin
                    miso  <= tx_sh[15];
                    tx_sh <= {tx_sh[14:0], 1'b0};
                end
            end
        end
    end

endmodule
`default_nettype wire

// [rtl/dss_selftest.sv]
`timescale 1ns/1ps
`default_nettype none
module dss_selftest #(
    parameter int ST_CYCLES = dss_pkg::ST_CYCLES
) (
    // Clock and reset
    input  wire logic               clk,
    input  wire logic               srst,
    // Control
    input  wire logic               auto_start,
    input  wire logic               manual_start,
    input  wire logic signed [15:0] accel,
    // Results
    output logic                    drive,
    output logic                    done,
    output logic                    fail,
    output logic signed [15:0]      delta
);
    import dss_pkg::*;

    localparam int HALF = ST_CYCLES / 2;
    localparam int CW   = $clog2(HALF + 1);

    if (ST_CYCLES < ST_MIN_CYCLES) begin : g_chk
        $error("dss_selftest: ST_CYCLES too small");
    end

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_BASE  = 2'b01,
        ST_DRIVE = 2'b10,
        ST_EVAL  = 2'b11
    } dss_st_e;

    dss_st_e            state;
    logic [CW-1:0]      cnt;
    logic               is_auto;
    logic signed [15:0] base;

    // ==========================================================
    // Sequencer: baseline, drive, measure, judge; a manual start skips baseline and measure
    always_ff @(posedge clk) begin
        if (srst) begin
            state   <= ST_IDLE;
            cnt     <= '0;
            is_auto <= 1'b0;
            base    <= 16'sh0000;
            delta   <= 16'sh0000;
            drive   <= 1'b0;
            done    <= 1'b0;
            fail    <= 1'b0;
        end else begin
            done <= 1'b0;
            fail <= 1'b0;
            case (state)
                ST_IDLE: begin
                    cnt <= '0;
                    if (auto_start) begin
                        is_auto <= 1'b1;
                        state   <= ST_BASE;
                    end else if (manual_start) begin
                        is_auto <= 1'b0;
                        drive   <= 1'b1;
                        state   <= ST_DRIVE;
                    end
                end
                ST_BASE: begin
                    cnt <= cnt + CW'(1);
                    if (cnt == CW'(HALF - 1)) begin
                        base  <= accel;
                        cnt   <= '0;
                        drive <= 1'b1;
                        state <= ST_DRIVE;
                    end
                end
                ST_DRIVE: begin
                    cnt <= cnt + CW'(1);
                    if (cnt == CW'(HALF - 1)) begin
                        if (is_auto) begin
                            delta <= accel - base;
                        end
                        drive <= 1'b0;
                        state <= ST_EVAL;
                    end
                end
                ST_EVAL: begin
                    done  <= 1'b1;
                    fail  <= is_auto & ((delta < $signed(DELTA_MIN)) ||
                             (delta > $signed(DELTA_MAX)));
                    state <= ST_IDLE;
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    AST_ST_DRIVE_HOLD: assert property (@(posedge clk) disable iff (srst)
        $rose(drive) |-> drive [*8])
        else $error("self-test drive dropped early");

    AST_ST_DONE_OFF: assert property (@(posedge clk) disable iff (srst)
        done |-> !drive && $past(state) == ST_EVAL)
        else $error("self-test done while driving");

endmodule
`default_nettype wire

// [rtl/dss_top.sv]
// Function
// - Error flag reads one when condition detected.
// - Flags latch until capture start or clear.
// - Supply flags set again at next sample.
// - Bits 14:12 show event capture trigger source.
// - Bits 10:8 flag captured peaks over threshold.
// - Bit 11 flags system alarm condition true.
// - Flash sum mismatch against memory sets bit 6.
// - Serial access during capture sets bit 4.
// - Clock count not multiple of 16 sets bit 3.
// - Bit 7 flags capture complete, data ready.
// - Bits 1 and 0 flag supply high, low.
// - Self-test command runs automatic delta sequence.
// - Manual self-test bit self-clears on completion.
// - Compensation enables in bits 1:0, reset 0x0003.
// - Delta register holds signed acceleration change.
// - Lot code is 24 bits over two registers.
// - Serial number register is read-only.
// - Flash write counter increments per flash write.
// - Start-up sequence ends in manual capture mode.
// - Reads return data of the previous request.
// - Clear command bit empties the status word.
`timescale 1ns/1ps
`default_nettype none
module dss_top #(
    parameter int ST_CYCLES      = dss_pkg::ST_CYCLES,
    parameter int STARTUP_CYCLES = dss_pkg::STARTUP_CYCLES
) (
    // Clock and reset
    input  wire logic                clk,
    input  wire logic                srst,
    // Serial port
    input  wire logic                sclk,
    input  wire logic                cs_n,
    input  wire logic                mosi,
    output logic                     miso,
    output logic                     miso_oe,
    // Supply monitor pins
    input  wire logic                power_good,
    input  wire logic                supply_high,
    input  wire logic                supply_low,
    // Sampling and capture engine
    input  wire logic                sample_tick,
    input  wire logic signed [15:0]  accel_sample,
    input  wire logic                capture_start,
    input  wire logic                capture_busy,
    input  wire dss_pkg::dss_events_s events,
    // Flash engine
    input  wire logic                flash_write,
    input  wire logic                sum_valid,
    input  wire logic [15:0]         sram_sum,
    input  wire logic [15:0]         flash_sum,
    // Identification fuses
    input  wire logic [23:0]         lot_code,
    input  wire logic [7:0]          lot_internal,
    input  wire logic [15:0]         serial_number,
    // Control outputs
    output logic                     capture_request,
    output logic                     flash_test_request,
    output logic                     selftest_drive,
    output logic [1:0]               supply_comp_en,
    output logic                     manual_capture_mode
);
    import dss_pkg::*;

    localparam int SUW = $clog2(STARTUP_CYCLES + 1);

    if (STARTUP_CYCLES < 1) begin : g_chk
        $error("dss_top: STARTUP_CYCLES must be positive");
    end

    dss_frame_s         frame;
    logic               frame_valid;
    logic               frame_error;
    logic [15:0]        tx_hold;
    logic [15:0]        rd_word;
    logic [15:0]        diag;
    logic [15:0]        diag_set;
    logic               diag_clr;
    logic [15:0]        misc;
    logic [15:0]        flash_write_counter;
    logic signed [15:0] delta;
    logic               st_done;
    logic               st_fail;
    logic [1:0]         pg_q;
    logic [1:0]         hi_q;
    logic [1:0]         lo_q;
    logic [SUW-1:0]     su_cnt;
    logic               wr_en;
    logic               wr_glob;
    logic               wr_glob_hi;
    logic               wr_misc;
    logic               wr_misc_hi;
    logic               st_auto_start;
    logic               st_manual_start;
    logic [6:0]         word_addr;

    // ==========================================================
    // Serial port and self-test engine
    dss_spi_slave u_spi (
        .clk         (clk),
        .srst        (srst),
        .sclk        (sclk),
        .cs_n        (cs_n),
        .mosi        (mosi),
        .miso        (miso),
        .miso_oe     (miso_oe),
        .tx_word     (tx_hold),
        .frame       (frame),
        .frame_valid (frame_valid),
        .frame_error (frame_error)
    );

    dss_selftest #(
        .ST_CYCLES (ST_CYCLES)
    ) u_st (
        .clk          (clk),
        .srst         (srst),
        .auto_start   (st_auto_start),
        .manual_start (st_manual_start),
        .accel        (accel_sample),
        .drive        (selftest_drive),
        .done         (st_done),
        .fail         (st_fail),
        .delta        (delta)
    );

    // ==========================================================
    // Supply pin synchronisers
    always_ff @(posedge clk) begin
        if (srst) begin
            pg_q <= 2'h0;
            hi_q <= 2'h0;
            lo_q <= 2'h0;
        end else begin
            pg_q <= {pg_q[0], power_good};
            hi_q <= {hi_q[0], supply_high};
            lo_q <= {lo_q[0], supply_low};
        end
    end

    // ==========================================================
    // Write decode; byte writes, even address is the low byte
    assign word_addr     = frame.addr & ADDR_WORD_MASK;
    assign wr_en         = frame_valid & frame.wr;
    assign wr_glob       = wr_en & (frame.addr == ADDR_GLOB);
    assign wr_glob_hi    = wr_en & (frame.addr == ADDR_GLOB_HI);
    assign wr_misc       = wr_en & (frame.addr == ADDR_MISC);
    assign wr_misc_hi    = wr_en & (frame.addr == ADDR_MISC_HI);
    assign diag_clr      = capture_start |
                           (wr_glob & frame.data[GLOB_CLR_BIT]);
    assign st_auto_start = wr_glob & frame.data[GLOB_ST_BIT];
    // Writing the manual bit again while it runs is ignored.
    assign st_manual_start = wr_misc_hi & frame.data[MISC_ST_BIT - 8] &
                             ~misc[MISC_ST_BIT];

    // ==========================================================
    // Command pulses to the capture and flash engines
    always_ff @(posedge clk) begin
        if (srst) begin
            capture_request    <= 1'b0;
            flash_test_request <= 1'b0;
        end else begin
            capture_request    <= wr_glob_hi &
                                  frame.data[GLOB_CAPT_BIT - 8];
            flash_test_request <= wr_glob & frame.data[GLOB_FT_BIT];
        end
    end

    // ==========================================================
    // Miscellaneous control
    always_ff @(posedge clk) begin
        if (srst) begin
            misc <= MISC_RESET;
        end else begin
            if (wr_misc) begin
                misc[1:0] <= frame.data[1:0];
            end
            if (st_manual_start) begin
                misc[MISC_ST_BIT] <= 1'b1;
            end else if (st_done) begin
                misc[MISC_ST_BIT] <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            supply_comp_en <= MISC_RESET[1:0];
        end else begin
            supply_comp_en <= wr_misc ? frame.data[1:0] : misc[1:0];
        end
    end

    // ==========================================================
    // Diagnostic status: sticky, a new event wins over a clear
    always_comb begin
        diag_set = 16'h0000;
        diag_set[DG_SUP_LO] = (sample_tick | events.capture_done) &
                              lo_q[1];
        diag_set[DG_SUP_HI] = (sample_tick | events.capture_done) &
                              hi_q[1];
        diag_set[DG_FLASH_UPD]  = events.flash_upd_fail;
        diag_set[DG_SPI]        = frame_error;
        diag_set[DG_CAPT_VIOL]  = frame_valid & capture_busy;
        diag_set[DG_ST]         = st_done & st_fail;
        diag_set[DG_FLASH_TEST] = sum_valid & (sram_sum != flash_sum);
        diag_set[DG_READY]      = events.capture_done;
        diag_set[DG_SYS]        = events.sys_alarm;
        diag_set[DG_PEAK_LO +: 3] = events.peak;
        diag_set[DG_SRC_LO +: 3]  = events.event_src;
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            diag <= DIAG_RESET;
        end else begin
            diag <= (diag_clr ? 16'h0000 : diag) | diag_set;
        end
    end

    // ==========================================================
    // Flash write counter
    always_ff @(posedge clk) begin
        if (srst) begin
            flash_write_counter <= 16'h0000;
        end else if (flash_write) begin
            flash_write_counter <= flash_write_counter + 16'h0001;
        end
    end

    // ==========================================================
    // Start-up: counts once the supply is good, then manual mode
    always_ff @(posedge clk) begin
        if (srst || !pg_q[1]) begin
            su_cnt              <= '0;
            manual_capture_mode <= 1'b0;
        end else if (su_cnt != SUW'(STARTUP_CYCLES)) begin
            su_cnt <= su_cnt + SUW'(1);
        end else begin
            manual_capture_mode <= 1'b1;
        end
    end

    // ==========================================================
    // Read path; the answer goes out in the following frame
    always_comb begin
        rd_word = 16'h0000;
        case (word_addr)
            ADDR_DIAG:      rd_word = diag & ~(16'h0001 << DG_RSV);
            ADDR_MISC:      rd_word = misc;
            ADDR_DELTA:     rd_word = delta;
            ADDR_LOT_LO:    rd_word = {lot_code[7:0], lot_internal};
            ADDR_LOT_HI:    rd_word = lot_code[23:8];
            ADDR_SERIAL:    rd_word = serial_number;
            ADDR_FLASH_WRITE_COUNTER: rd_word = flash_write_counter;
            default:        rd_word = 16'h0000;
        endcase
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            tx_hold <= 16'h0000;
        end else if (frame_valid && !frame.wr) begin
            tx_hold <= rd_word;
        end
    end

    // ==========================================================
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    sequence s_read_frame;
        frame_valid && !frame.wr;
    endsequence

    sequence s_clear_quiet;
        diag_clr && diag_set == 16'h0000;
    endsequence

    AST_FRAME_ERR: assert property (frame_error |=> diag[DG_SPI])
        else $error("framing error not flagged");

    AST_BUSY_ACCESS: assert property (
        frame_valid && capture_busy |=> diag[DG_CAPT_VIOL])
        else $error("access during capture not flagged");

    AST_CLEAR: assert property (s_clear_quiet |=> diag == 16'h0000)
        else $error("status not cleared");

    AST_STICKY: assert property (
        !diag_clr |=> (diag & $past(diag)) == $past(diag))
        else $error("status flag lost without clear");

    AST_RSV_ZERO: assert property (diag[DG_RSV] == 1'b0)
        else $error("reserved status bit set");

    AST_SUPPLY: assert property (
        sample_tick && lo_q[1] |=> diag[DG_SUP_LO])
        else $error("supply low not flagged at sample");

    AST_PIPE: assert property (
        s_read_frame |=> tx_hold == $past(rd_word) [*1] ##1
        tx_hold == $past(tx_hold) || frame_valid)
        else $error("read answer not held for next frame");

    AST_MISC_RESET: assert property (
        $past(srst) |-> misc == MISC_RESET)
        else $error("control register reset value wrong");

    AST_ST_SELFCLR: assert property (
        st_done && !st_manual_start |=> !misc[MISC_ST_BIT])
        else $error("manual self-test bit not cleared");

    AST_FLASH_WRITE_COUNTER: assert property (
        flash_write |=> flash_write_counter == $past(flash_write_counter) + 16'h0001)
        else $error("flash counter did not step");

    AST_MANUAL: assert property (
        manual_capture_mode |-> $past(pg_q[1]) &&
        su_cnt == SUW'(STARTUP_CYCLES))
        else $error("manual mode before start-up end");

endmodule
`default_nettype wire

// [sim/dss_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
module dss_host_model (
    // Clock
    input  wire logic clk,
    // Serial pins
    output logic      sclk,
    output logic      cs_n,
    output logic      mosi,
    input  wire logic miso
);
    // =========================================================
    // Mode 3 master, 160 ns serial clock, idle high.
    initial begin
        sclk = 1'b1;
        cs_n = 1'b1;
        mosi = 1'b0;
    end

    // Fewer than 16 clocks per frame is allowed, to provoke errors.
    task automatic xfer(input logic [15:0] w, input int n,
                        output logic [15:0] r);
        r = 16'h0000;
        @(posedge clk) cs_n <= 1'b0;
        for (int i = 0; i < n; i++) begin
            repeat (16) @(posedge clk);
            sclk <= 1'b0;
            mosi <= w[15 - i];
            repeat (16) @(posedge clk);
            sclk <= 1'b1;
            r = {r[14:0], miso};
        end
        repeat (8) @(posedge clk);
        cs_n <= 1'b1;
        mosi <= ~mosi;
        repeat (8) @(posedge clk);
    endtask
endmodule
`default_nettype wire

// [sim/tb.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin num_errors++; \
    $display("unexpected at %0t: %h vs %h", $time, (a), (e)); end end
module tb;
    import dss_pkg::*;
    // =========================================================
    // Stimulus and observation
    logic        clk = 0, srst = 1, pg = 0, sh = 0, sl = 0;
    logic        tick = 0, cst = 0, fw = 0, sv = 0, busy = 0;
    logic        sclk, cs_n, mosi, miso, drv, mcm, creq, ftr, moe;
    logic [1:0]  comp;
    logic [15:0] amp = 16'h0100, sram = 16'h0000, fsum = 16'h0000, r;
    logic signed [15:0] acc = 0;
    dss_events_s ev = '0;
    int          num_errors = 0, n_tests = 0, n_cap = 0, n_drv = 0, d0;
    int          n_ft = 0, n_oe = 0;

    initial forever #2.5 clk = ~clk;
    // The sensing element answers its drive one sample later.
    always @(posedge clk) acc <= drv ? amp : 16'h0000;
    always @(posedge clk) n_cap <= n_cap + creq;
    always @(posedge clk) n_drv <= n_drv + drv;
    always @(posedge clk) n_ft <= n_ft + ftr;
    always @(posedge clk) n_oe <= n_oe + moe;

    dss_host_model HOST (.clk(clk), .sclk(sclk), .cs_n(cs_n),
        .mosi(mosi), .miso(miso));
    dss_top #(.ST_CYCLES(16), .STARTUP_CYCLES(20)) DUT (.clk(clk),
        .srst(srst), .sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso),
        .miso_oe(moe), .power_good(pg), .supply_high(sh), .supply_low(sl),
        .sample_tick(tick), .accel_sample(acc), .capture_start(cst),
        .capture_busy(busy), .events(ev), .flash_write(fw),
        .sum_valid(sv), .sram_sum(sram), .flash_sum(fsum),
        .lot_code(24'hA5_C311), .lot_internal(8'h7E),
        .serial_number(16'h1234), .capture_request(creq),
        .flash_test_request(ftr), .selftest_drive(drv),
        .supply_comp_en(comp), .manual_capture_mode(mcm));

    // =========================================================
    // Access tasks
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        HOST.xfer({1'b1, a, d}, 16, r);
    endtask
    // The first answer belongs to the previous request and is dropped.
    task automatic rd(input logic [6:0] a, input logic [15:0] e);
        HOST.xfer({1'b0, a, 8'h00}, 16, r);
        HOST.xfer({1'b0, a, 8'h00}, 16, r);
        `CHK(r, e)
    endtask
    task automatic pulse(input logic [3:0] p, input dss_events_s v);
        @(posedge clk) {tick, cst, fw, sv} <= p;
        ev <= v;
        @(posedge clk) {tick, cst, fw, sv} <= 4'h0;
        ev <= '0;
    endtask
    task automatic results;
        $display("errors %0d compares %0d", num_errors, n_tests);
        if (num_errors == 0 && n_tests > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    // =========================================================
    // Tests
    initial begin
        repeat (16) @(posedge clk);
        srst <= 0;
        pg <= 1;
        repeat (40) @(posedge clk);
        `CHK(mcm, 1'b1)
        rd(ADDR_MISC, MISC_RESET);
        rd(ADDR_DIAG, DIAG_RESET);
        rd(ADDR_LOT_LO, 16'h117E);
        rd(ADDR_LOT_HI, 16'hA5C3);
        rd(ADDR_SERIAL, 16'h1234);
        rd(7'h60, 16'h0000);
        wr(ADDR_MISC, 8'h01);
        `CHK(comp, 2'b01)
        $display("done ident");
        pulse(4'h0, 9'h156);
        rd(ADDR_DIAG, 16'h5A80);
        pulse(4'h0, 9'h0A9);
        rd(ADDR_DIAG, 16'h7F84);
        wr(ADDR_GLOB, 8'h10);
        rd(ADDR_DIAG, 16'h0000);
        sh <= 1;
        sl <= 1;
        pulse(4'h8, '0);
        wr(ADDR_GLOB, 8'h10);
        pulse(4'h8, '0);
        rd(ADDR_DIAG, 16'h0003);
        sh <= 0;
        sl <= 0;
        pulse(4'h4, '0);
        sram <= 16'h00A5;
        fsum <= 16'h00A5;
        pulse(4'h1, '0);
        rd(ADDR_DIAG, 16'h0000);
        $display("done flags");
        sram <= 16'h0001;
        pulse(4'h1, '0);
        repeat (3) pulse(4'h2, '0);
        rd(ADDR_FLASH_WRITE_COUNTER, 16'h0003);
        HOST.xfer(16'hFFFF, 12, r);
        busy <= 1;
        wr(7'h60, 8'h00);
        busy <= 0;
        rd(ADDR_DIAG, 16'h0058);
        $display("done flash and link");
        wr(ADDR_GLOB, 8'h30);
        `CHK(n_ft, 1)
        wr(ADDR_GLOB, 8'h04);
        rd(ADDR_DELTA, 16'h0100);
        rd(ADDR_DIAG, 16'h0000);
        amp <= 16'h0008;
        wr(ADDR_GLOB, 8'h04);
        rd(ADDR_DELTA, 16'h0008);
        rd(ADDR_DIAG, 16'h0020);
        d0 = n_drv;
        wr(ADDR_MISC_HI, 8'h01);
        rd(ADDR_MISC, 16'h0001);
        `CHK(n_drv - d0, 8)
        wr(ADDR_GLOB_HI, 8'h08);
        `CHK(n_cap, 1)
        `CHK(n_oe != 0, 1'b1)
        $display("done selftest and capture");
        results();
    end

    initial begin
        repeat (60000) @(posedge clk);
        num_errors++;
        results();
    end
endmodule
`default_nettype wire
